/* hdl/dtpb_pkg.sv */
// dtpb_pkg: register map, field positions and reset values of the
// down timer / pwm / buzzer block.
// assumes an 8-bit register port with one-cycle read latency.
package dtpb_pkg;
   localparam logic [2:0] ADDR_CTRL_ONE = 3'h0;
   localparam logic [2:0] ADDR_CTRL_TWO = 3'h1;
   localparam logic [2:0] ADDR_HIGH_BITS = 3'h2;
   localparam logic [2:0] ADDR_RELOAD_LOW = 3'h3;
   localparam logic [2:0] ADDR_DUTY_LOW = 3'h4;
   localparam logic [2:0] ADDR_PRESCALE_CNT = 3'h5;
   localparam logic [2:0] ADDR_BUZZER_CTRL = 3'h6;
   localparam logic [2:0] ADDR_IRQ = 3'h7;
   // control one
   localparam int C1_ENABLE = 0;
   localparam int C1_RELOAD = 1;
   localparam int C1_ONE_SHOT = 2;
   localparam int C1_ACT_LOW = 6;
   localparam int C1_PWM_OE = 7;
   // control two
   localparam int C2_EDGE = 4;
   localparam int C2_SOURCE = 5;
   localparam int C2_PS_EN_N = 3;
   // buzzer control: bit 7 enable, bit 3 source, bits 2:0 frequency select
   localparam int BZ_ENABLE = 7;
   localparam int BZ_SRC = 3;
   // irq register: flag bit 4, timer enable bit 0, global bit 7
   localparam int IRQ_FLAG = 4;
   localparam int IRQ_TIE = 0;
   localparam int IRQ_GIE = 7;
   localparam logic [7:0] RESET_CTRL_TWO = 8'h08;
   localparam logic [9:0] COUNT_FULL = 10'h3FF;
endpackage

/* hdl/dtpb_timer.sv */
// dtpb_timer: ten-bit down timer with prescaler, pwm and buzzer on one pin.
// assumes one clock; external count pin synchronous to it.
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/10ps
// Operation
// RULE_01: ten-bit counter decrements per selected tick
// RULE_02: reload high first; applied at underflow
// RULE_03: disabled timer loads on low write
// RULE_04: timer read returns live count
// RULE_05: enable bit starts and stops counting
// RULE_06: source bit picks pin or instruction clock
// RULE_07: edge bit picks falling or rising edge
// RULE_08: active-low prescaler enable, three-bit ratio
// RULE_09: prescaler count readable
// RULE_10: one-shot counts down once, stops
// RULE_11: continuous restarts from reload or 0x3FF
// RULE_12: underflow sets flag; gated interrupt request
// RULE_13: flag cleared only by writing zero
// RULE_14: pwm enable drives shared pin output
// RULE_15: polarity bit selects active low
// RULE_16: ten-bit duty; zero never active
// RULE_17: software keeps duty within reload
// RULE_18: duty buffered, applied at underflow
// RULE_19: buzzer enable drives shared pin output
// RULE_20: buzzer source prescaler or timer output
// RULE_21: buzzer divides source by field ratio
// RULE_22: prescale ratio two to select plus one
// RULE_23: buzzer toggles, ratio two to code plus one
// RULE_24: pwm active until elapsed reaches duty
// RULE_25: pwm wins the shared pin
module dtpb_timer (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // count sources
   input wire logic instr_tick,
   input wire logic external_count_clock_pin,
   // pin and interrupt
   output logic shared_output_pin,
   output logic shared_pin_oe,
   output logic irq_request
);
   typedef struct packed {
      logic [7:0] timer_control_one;
      logic [7:0] timer_control_two;
      logic [7:0] high_bits_register;
      logic [7:0] timer_reload_low;
      logic [7:0] duty_low;
      logic [7:0] buzzer_control;
      logic underflow_flag;
      logic underflow_irq_enable;
      logic global_interrupt_enable;
      logic [9:0] count;
      logic [9:0] reload_buf;
      logic [9:0] active_reload;
      logic [9:0] duty_buf;
      logic [9:0] pwm_duty_value;
      logic [7:0] prescaler_count_value;
      logic [7:0] buzzer_div;
      logic buzzer_output;
      logic ext_prev;
      logic [7:0] rdata;
   } dtpb_state_s;

   dtpb_state_s state;
   dtpb_state_s next_state;

   logic src_tick;
   logic ps_tick;
   logic timer_tick;
   logic underflow;
   logic [7:0] ps_mask;
   logic [7:0] bz_mask;
   logic bz_src;
   logic [9:0] elapsed;
   logic pwm_active;
   logic pwm_output;
   logic running;

   // edge detect on the pin; falling when edge bit set
   always_comb begin
      if (state.timer_control_two[dtpb_pkg::C2_SOURCE]) begin // RULE_06
         if (state.timer_control_two[dtpb_pkg::C2_EDGE]) begin // RULE_07
            src_tick = state.ext_prev && !external_count_clock_pin;
         end else begin
            src_tick = !state.ext_prev && external_count_clock_pin;
         end
      end else begin
         src_tick = instr_tick;
      end
   end

   // ratio 2^(sel+1): tick when low sel+1 bits are all ones, before they wrap to zero
   always_comb begin
      ps_mask = 8'((9'h002 << state.timer_control_two[2:0]) - 9'h001);
   end // RULE_22
   assign ps_tick = src_tick
      && ((state.prescaler_count_value & ps_mask) == ps_mask); // RULE_08
   assign running = state.timer_control_one[dtpb_pkg::C1_ENABLE]; // RULE_05
   assign timer_tick = running
      && (state.timer_control_two[dtpb_pkg::C2_PS_EN_N] ? src_tick
      : ps_tick); // RULE_08
   assign underflow = timer_tick && (state.count == 10'h000); // RULE_10

   // elapsed input clocks within the frame
   assign elapsed = state.active_reload - state.count;
   assign pwm_active = running && (elapsed < state.pwm_duty_value); // RULE_24
   assign pwm_output = pwm_active
      ^ state.timer_control_one[dtpb_pkg::C1_ACT_LOW]; // RULE_15

   assign bz_mask = 8'((9'h002 << state.buzzer_control[2:0]) - 9'h001);
   assign bz_src = state.buzzer_control[dtpb_pkg::BZ_SRC] ? underflow
      : ps_tick; // RULE_20

   always_comb begin
      next_state = state;
      next_state.ext_prev = external_count_clock_pin;
      next_state.rdata = 8'h00;
      if (src_tick
          && !state.timer_control_two[dtpb_pkg::C2_PS_EN_N]) begin
         next_state.prescaler_count_value =
            state.prescaler_count_value + 8'h01;
      end
      if (bz_src) begin // RULE_21
         if ((state.buzzer_div & bz_mask) == bz_mask) begin
            next_state.buzzer_div = 8'h00;
            next_state.buzzer_output = !state.buzzer_output; // RULE_23
         end else begin
            next_state.buzzer_div = state.buzzer_div + 8'h01;
         end
      end
      if (timer_tick) begin
         if (underflow) begin
            next_state.pwm_duty_value = state.duty_buf; // RULE_18
            next_state.active_reload = state.reload_buf; // RULE_02
            if (state.timer_control_one[dtpb_pkg::C1_ONE_SHOT]) begin
               next_state.timer_control_one[dtpb_pkg::C1_ENABLE] = 1'b0;
               next_state.count = state.reload_buf; // RULE_10
            end else if (state.timer_control_one[dtpb_pkg::C1_RELOAD]) begin
               next_state.count = state.reload_buf; // RULE_11
            end else begin
               next_state.count = dtpb_pkg::COUNT_FULL; // RULE_11
               next_state.active_reload = dtpb_pkg::COUNT_FULL;
            end
         end else begin
            next_state.count = state.count - 10'h001; // RULE_01
         end
      end
      if (reg_write) begin
         unique case (reg_addr)
            dtpb_pkg::ADDR_CTRL_ONE: next_state.timer_control_one = reg_wdata;
            dtpb_pkg::ADDR_CTRL_TWO: next_state.timer_control_two = reg_wdata;
            dtpb_pkg::ADDR_HIGH_BITS: begin
               next_state.high_bits_register = reg_wdata;
            end
            dtpb_pkg::ADDR_RELOAD_LOW: begin
               next_state.timer_reload_low = reg_wdata;
               next_state.reload_buf = {state.high_bits_register[5:4],
                  reg_wdata}; // RULE_02
               if (!running) begin
                  next_state.count = {state.high_bits_register[5:4],
                     reg_wdata}; // RULE_03
                  next_state.active_reload = {state.high_bits_register[5:4],
                     reg_wdata};
               end
            end
            dtpb_pkg::ADDR_DUTY_LOW: begin
               next_state.duty_low = reg_wdata;
               next_state.duty_buf = {state.high_bits_register[1:0],
                  reg_wdata}; // RULE_16
            end
            dtpb_pkg::ADDR_PRESCALE_CNT: begin
            end
            dtpb_pkg::ADDR_BUZZER_CTRL: next_state.buzzer_control = reg_wdata;
            dtpb_pkg::ADDR_IRQ: begin
               next_state.underflow_irq_enable = reg_wdata[dtpb_pkg::IRQ_TIE];
               next_state.global_interrupt_enable =
                  reg_wdata[dtpb_pkg::IRQ_GIE];
               // writing one leaves it alone; only zero clears
               if (!reg_wdata[dtpb_pkg::IRQ_FLAG]) begin
                  next_state.underflow_flag = 1'b0; // RULE_13
               end
            end
         endcase
      end
      // set wins over a same-cycle clear
      if (underflow) begin
         next_state.underflow_flag = 1'b1; // RULE_12
      end
      if (reg_read) begin
         unique case (reg_addr)
            dtpb_pkg::ADDR_CTRL_ONE: next_state.rdata = state.timer_control_one;
            dtpb_pkg::ADDR_CTRL_TWO: next_state.rdata = state.timer_control_two;
            dtpb_pkg::ADDR_HIGH_BITS: begin
               next_state.rdata = {state.high_bits_register[7:2],
                  state.count[9:8]};
            end
            dtpb_pkg::ADDR_RELOAD_LOW: begin
               next_state.rdata = state.count[7:0]; // RULE_04
            end
            dtpb_pkg::ADDR_DUTY_LOW: next_state.rdata = state.duty_low;
            dtpb_pkg::ADDR_PRESCALE_CNT: begin
               next_state.rdata = state.prescaler_count_value; // RULE_09
            end
            dtpb_pkg::ADDR_BUZZER_CTRL: next_state.rdata = state.buzzer_control;
            dtpb_pkg::ADDR_IRQ: begin
               next_state.rdata = {state.global_interrupt_enable, 2'h0,
                  state.underflow_flag, 3'h0, state.underflow_irq_enable};
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state <= '0;
         state.timer_control_two <= dtpb_pkg::RESET_CTRL_TWO;
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata = state.rdata;
   assign irq_request = state.underflow_flag && state.underflow_irq_enable
      && state.global_interrupt_enable; // RULE_12
   // pwm has priority over the buzzer on the shared pin
   assign shared_output_pin =
      state.timer_control_one[dtpb_pkg::C1_PWM_OE] ? pwm_output
      : state.buzzer_output; // RULE_25
   assign shared_pin_oe = state.timer_control_one[dtpb_pkg::C1_PWM_OE]
      || state.buzzer_control[dtpb_pkg::BZ_ENABLE]; // RULE_14 RULE_19

   // checks
   a_flag_sets: assert property (@(posedge clock) disable iff (reset)
      underflow |=> state.underflow_flag) // RULE_12
      else $error("flag not set on underflow");
   a_flag_holds: assert property (@(posedge clock) disable iff (reset)
      state.underflow_flag && !(reg_write && reg_addr == dtpb_pkg::ADDR_IRQ)
      |=> state.underflow_flag) // RULE_13
      else $error("flag cleared by hardware");
   a_count_dec: assert property (@(posedge clock) disable iff (reset)
      timer_tick && !underflow && !reg_write
      |=> state.count == $past(state.count) - 10'h001) // RULE_01
      else $error("count did not decrement");
   a_stop_idle: assert property (@(posedge clock) disable iff (reset)
      !running && !reg_write |=> state.count == $past(state.count)) // RULE_05
      else $error("count moved while stopped");
   a_one_shot: assert property (@(posedge clock) disable iff (reset)
      underflow && state.timer_control_one[dtpb_pkg::C1_ONE_SHOT]
      && !reg_write |=> !running) // RULE_10
      else $error("one-shot did not stop");
   a_full_restart: assert property (@(posedge clock) disable iff (reset)
      underflow && !state.timer_control_one[dtpb_pkg::C1_ONE_SHOT]
      && !state.timer_control_one[dtpb_pkg::C1_RELOAD] && !reg_write
      |=> state.count == dtpb_pkg::COUNT_FULL) // RULE_11
      else $error("no restart from full count");
   a_idle_load: assert property (@(posedge clock) disable iff (reset)
      reg_write && reg_addr == dtpb_pkg::ADDR_RELOAD_LOW && !running
      |=> state.count == {$past(state.high_bits_register[5:4]),
      $past(reg_wdata)}) // RULE_03
      else $error("idle reload not immediate");
   a_duty_zero: assert property (@(posedge clock) disable iff (reset)
      state.pwm_duty_value == 10'h000 |-> !pwm_active) // RULE_16
      else $error("zero duty went active");
   a_read_live: assert property (@(posedge clock) disable iff (reset)
      reg_read && reg_addr == dtpb_pkg::ADDR_RELOAD_LOW
      |=> reg_rdata == $past(state.count[7:0])) // RULE_04
      else $error("read not live count");
   a_pin_prio: assert property (@(posedge clock) disable iff (reset)
      state.timer_control_one[dtpb_pkg::C1_PWM_OE]
      |-> shared_pin_oe && shared_output_pin == pwm_output) // RULE_25
      else $error("pwm lost the pin");

   // interrupt gating and flag clearing
   a_irq_gie: assert property ( // RULE_12
      @(posedge clock) disable iff (reset)
      !state.global_interrupt_enable |-> !irq_request)
      else $error("irq without global enable");
   a_flag_clear: assert property ( // RULE_13
      @(posedge clock) disable iff (reset)
      reg_write && reg_addr == dtpb_pkg::ADDR_IRQ
      && !reg_wdata[dtpb_pkg::IRQ_FLAG] && !underflow
      |=> !state.underflow_flag)
      else $error("flag not cleared by zero write");

   // shared pin routing; pwm output wins over the buzzer
   a_pin_off: assert property ( // RULE_14
      @(posedge clock) disable iff (reset)
      !state.timer_control_one[dtpb_pkg::C1_PWM_OE]
      && !state.buzzer_control[dtpb_pkg::BZ_ENABLE] |-> !shared_pin_oe)
      else $error("pin driven with both outputs off");
   a_buzz_pin: assert property ( // RULE_19
      @(posedge clock) disable iff (reset)
      state.buzzer_control[dtpb_pkg::BZ_ENABLE]
      && !state.timer_control_one[dtpb_pkg::C1_PWM_OE]
      |-> shared_pin_oe && shared_output_pin == state.buzzer_output)
      else $error("buzzer not on pin");
   a_pwm_idle: assert property ( // RULE_15
      @(posedge clock) disable iff (reset)
      state.timer_control_one[dtpb_pkg::C1_PWM_OE] && !pwm_active
      |-> shared_output_pin == state.timer_control_one[dtpb_pkg::C1_ACT_LOW])
      else $error("inactive pwm level wrong");

   // prescaler: frozen while off, one step per source tick
   a_ps_hold: assert property ( // RULE_08
      @(posedge clock) disable iff (reset)
      state.timer_control_two[dtpb_pkg::C2_PS_EN_N]
      |=> $stable(state.prescaler_count_value))
      else $error("prescaler moved while off");
   a_ps_step: assert property ( // RULE_08
      @(posedge clock) disable iff (reset)
      src_tick && !state.timer_control_two[dtpb_pkg::C2_PS_EN_N]
      |=> state.prescaler_count_value
      == $past(state.prescaler_count_value) + 8'h01)
      else $error("prescaler missed a tick");
   a_ps_read: assert property ( // RULE_09
      @(posedge clock) disable iff (reset)
      reg_read && reg_addr == dtpb_pkg::ADDR_PRESCALE_CNT
      |=> reg_rdata == $past(state.prescaler_count_value))
      else $error("prescaler read wrong");
   a_rdata_idle: assert property ( // RULE_04
      @(posedge clock) disable iff (reset)
      !reg_read |=> reg_rdata == 8'h00)
      else $error("read data not zero when idle");

   // double buffers: captured at low write, applied at underflow
   a_reload_buf: assert property ( // RULE_02
      @(posedge clock) disable iff (reset)
      reg_write && reg_addr == dtpb_pkg::ADDR_RELOAD_LOW
      |=> state.reload_buf == {$past(state.high_bits_register[5:4]),
      $past(reg_wdata)})
      else $error("reload buffer not captured");
   a_duty_buf: assert property ( // RULE_16
      @(posedge clock) disable iff (reset)
      reg_write && reg_addr == dtpb_pkg::ADDR_DUTY_LOW
      |=> state.duty_buf == {$past(state.high_bits_register[1:0]),
      $past(reg_wdata)})
      else $error("duty buffer not captured");
   a_duty_load: assert property ( // RULE_18
      @(posedge clock) disable iff (reset)
      underflow |=> state.pwm_duty_value == $past(state.duty_buf))
      else $error("duty not applied at underflow");
   a_duty_hold: assert property ( // RULE_18
      @(posedge clock) disable iff (reset)
      !underflow |=> $stable(state.pwm_duty_value))
      else $error("duty changed between underflows");
   a_cont_reload: assert property ( // RULE_11
      @(posedge clock) disable iff (reset)
      underflow && !state.timer_control_one[dtpb_pkg::C1_ONE_SHOT]
      && state.timer_control_one[dtpb_pkg::C1_RELOAD] && !reg_write
      |=> state.count == $past(state.reload_buf))
      else $error("no restart from reload value");
   a_shot_reload: assert property ( // RULE_10
      @(posedge clock) disable iff (reset)
      underflow && state.timer_control_one[dtpb_pkg::C1_ONE_SHOT]
      && !reg_write |=> state.count == $past(state.reload_buf))
      else $error("one-shot lost its start value");

   // count source and edge selection
   a_instr_only: assert property ( // RULE_06
      @(posedge clock) disable iff (reset)
      !state.timer_control_two[dtpb_pkg::C2_SOURCE] && !instr_tick
      |-> !src_tick)
      else $error("tick without instruction clock");
   a_ext_rise: assert property ( // RULE_07
      @(posedge clock) disable iff (reset)
      state.timer_control_two[dtpb_pkg::C2_SOURCE]
      && !state.timer_control_two[dtpb_pkg::C2_EDGE]
      && state.timer_control_two[dtpb_pkg::C2_PS_EN_N] && running
      && !state.ext_prev && external_count_clock_pin |-> timer_tick)
      else $error("rising edge not counted");
   a_ext_fall: assert property ( // RULE_07
      @(posedge clock) disable iff (reset)
      state.timer_control_two[dtpb_pkg::C2_SOURCE]
      && state.timer_control_two[dtpb_pkg::C2_EDGE]
      && state.timer_control_two[dtpb_pkg::C2_PS_EN_N] && running
      && state.ext_prev && !external_count_clock_pin |-> timer_tick)
      else $error("falling edge not counted");
   a_buzz_toggle: assert property ( // RULE_23
      @(posedge clock) disable iff (reset)
      bz_src && ((state.buzzer_div & bz_mask) == bz_mask)
      |=> state.buzzer_output != $past(state.buzzer_output))
      else $error("buzzer did not toggle");

   c_underflow: cover property (@(posedge clock) disable iff (reset)
      underflow);
   c_one_shot: cover property (@(posedge clock) disable iff (reset)
      underflow && state.timer_control_one[dtpb_pkg::C1_ONE_SHOT]);
   c_pwm_on: cover property (@(posedge clock) disable iff (reset)
      pwm_active && state.timer_control_one[dtpb_pkg::C1_PWM_OE]);
   c_irq: cover property (@(posedge clock) disable iff (reset) irq_request);
   c_buzz: cover property (@(posedge clock) disable iff (reset)
      $rose(state.buzzer_output));
endmodule

/* dv/down_timer_pwm_buzzer_test.sv */
// down_timer_pwm_buzzer_test: self-checking bench for dtpb_timer.
// assumes the dtpb_pkg register map and one-cycle read latency.
`timescale 1ns/10ps
module down_timer_pwm_buzzer_test;
   logic clock, reset, reg_write, reg_read, instr_tick, ext_pin;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, b, p0;
   logic shared_output_pin, shared_pin_oe, irq_request;
   logic [9:0] c, v, w;
   int miscompares = 0, n_tests = 0, cycles = 0, k, hi, tg, e;

   dtpb_timer u_dtpb_timer (
      .clock(clock), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .instr_tick(instr_tick),
      .external_count_clock_pin(ext_pin),
      .shared_output_pin(shared_output_pin),
      .shared_pin_oe(shared_pin_oe), .irq_request(irq_request));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // cuts a hang short; the whole run needs a few thousand cycles
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 12000) begin
         miscompares = miscompares + 1;
         report_and_stop();
      end
   end

   task automatic chk(string what, logic [9:0] exp, logic [9:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(logic [2:0] a, logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask

   task automatic rd(logic [2:0] a, output logic [7:0] q);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 q = reg_rdata;
   endtask

   task automatic read_count(output logic [9:0] q);
      logic [7:0] lo, hb;
      rd(dtpb_pkg::ADDR_RELOAD_LOW, lo);
      rd(dtpb_pkg::ADDR_HIGH_BITS, hb);
      q = {hb[1:0], lo};
   endtask

   // stops the timer so the low write loads the counter at once
   task automatic load(logic [9:0] r, logic [9:0] d);
      wr(dtpb_pkg::ADDR_CTRL_ONE, 8'h00);
      wr(dtpb_pkg::ADDR_HIGH_BITS, {2'h0, r[9:8], 2'h0, d[9:8]});
      wr(dtpb_pkg::ADDR_RELOAD_LOW, r[7:0]);
      wr(dtpb_pkg::ADDR_DUTY_LOW, d[7:0]);
   endtask

   task automatic tick(int n);
      repeat (n) begin
         @(posedge clock);
         instr_tick <= 1'b1;
      end
      @(posedge clock);
      instr_tick <= 1'b0;
   endtask

   // ticks every cycle, counting high samples and pin changes
   task automatic run(int n, output int h, output int t);
      logic last;
      h = 0;
      t = 0;
      last = shared_output_pin;
      repeat (n) begin
         @(posedge clock);
         instr_tick <= 1'b1;
         #1 h += (shared_output_pin === 1'b1);
         t += (shared_output_pin !== last);
         last = shared_output_pin;
      end
      @(posedge clock);
      instr_tick <= 1'b0;
   endtask

   initial begin
      reset = 1'b1;
      reg_write = 1'b0;
      reg_read = 1'b0;
      instr_tick = 1'b0;
      ext_pin = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      void'($urandom(32'h5bd93c40));
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      rd(dtpb_pkg::ADDR_CTRL_TWO, b);
      chk("ctrl_two", 10'(dtpb_pkg::RESET_CTRL_TWO), 10'(b));
      $display("test reset done");
      v = 10'($urandom_range(1023, 300));
      w = 10'($urandom_range(1023, 1));
      load(v, 10'h000);
      read_count(c);
      chk("load", v, c);
      wr(dtpb_pkg::ADDR_CTRL_ONE, 8'h03);
      k = $urandom_range(250, 1);
      tick(k);
      wr(dtpb_pkg::ADDR_HIGH_BITS, {2'h0, w[9:8], 4'h0});
      wr(dtpb_pkg::ADDR_RELOAD_LOW, w[7:0]);
      read_count(c);
      chk("count", v - 10'(k), c);
      tick(int'(v) - k + 1);
      read_count(c);
      chk("reload", w, c);
      wr(dtpb_pkg::ADDR_CTRL_ONE, 8'h00);
      tick(5);
      read_count(c);
      chk("stopped", w, c);
      $display("test count done");
      load(10'h003, 10'h000);
      wr(dtpb_pkg::ADDR_IRQ, 8'h81);
      wr(dtpb_pkg::ADDR_CTRL_ONE, 8'h03);
      tick(3);
      #1;
      chk("irq_idle", 10'h000, 10'(irq_request));
      tick(1);
      rd(dtpb_pkg::ADDR_IRQ, b);
      chk("flag", 10'h001, 10'(b[4]));
      chk("irq", 10'h001, 10'(irq_request));
      wr(dtpb_pkg::ADDR_IRQ, 8'h91);
      tick(6);
      rd(dtpb_pkg::ADDR_IRQ, b);
      chk("flag_held", 10'h001, 10'(b[4]));
      wr(dtpb_pkg::ADDR_IRQ, 8'h01);
      rd(dtpb_pkg::ADDR_IRQ, b);
      chk("flag_clear", 10'h000, 10'(b[4]));
      tick(4);
      rd(dtpb_pkg::ADDR_IRQ, b);
      chk("flag_again", 10'h001, 10'(b[4]));
      chk("irq_no_gie", 10'h000, 10'(irq_request));
      $display("test flag done");
      load(10'h003, 10'h000);
      wr(dtpb_pkg::ADDR_CTRL_ONE, 8'h01);
      tick(4);
      read_count(c);
      chk("full", dtpb_pkg::COUNT_FULL, c);
      load(10'h003, 10'h000);
      wr(dtpb_pkg::ADDR_CTRL_ONE, 8'h05);
      tick(9);
      read_count(c);
      chk("one_shot", 10'h003, c);
      $display("test modes done");
      for (int s = 0; s < 8; s++) begin
         load(10'h3FF, 10'h000);
         wr(dtpb_pkg::ADDR_CTRL_TWO, 8'(s));
         wr(dtpb_pkg::ADDR_CTRL_ONE, 8'h01);
         rd(dtpb_pkg::ADDR_PRESCALE_CNT, p0);
         k = $urandom_range(3 << s, 1);
         e = 0;
         for (int i = 0; i < k; i++)
            e += (((int'(p0) + i) % (2 << s)) == (2 << s) - 1);
         tick(k);
         read_count(c);
         chk("prescaled", 10'h3FF - 10'(e), c);
         rd(dtpb_pkg::ADDR_PRESCALE_CNT, b);
         chk("ps_count", 10'(p0 + 8'(k)), 10'(b));
      end
      $display("test prescaler done");
      // odd toggle count: k edges of the chosen kind, k-1 of the other
      for (int f = 0; f < 2; f++) begin
         @(posedge clock);
         ext_pin <= f[0];
         load(10'h200, 10'h000);
         wr(dtpb_pkg::ADDR_CTRL_TWO, f[0] ? 8'h38 : 8'h28);
         wr(dtpb_pkg::ADDR_CTRL_ONE, 8'h01);
         k = $urandom_range(20, 2);
         repeat (2 * k - 1) begin
            @(posedge clock);
            ext_pin <= ~ext_pin;
            instr_tick <= 1'($urandom);
            repeat (2) @(posedge clock);
         end
         @(posedge clock);
         instr_tick <= 1'b0;
         repeat (4) @(posedge clock);
         read_count(c);
         chk("ext_edges", 10'h200 - 10'(k), c);
      end
      wr(dtpb_pkg::ADDR_CTRL_TWO, 8'h08);
      $display("test external done");
      for (int t = 0; t < 3; t++) begin
         v = 10'($urandom_range(40, 8));
         // duty kept within the frame reload
         w = (t == 0) ? 10'h000 : (t == 1) ? v : 10'($urandom_range(v - 1, 1));
         load(v, w);
         wr(dtpb_pkg::ADDR_CTRL_ONE, {1'b1, t[0], 6'h03});
         tick(int'(v) + 2);
         run(2 * (int'(v) + 1), hi, tg);
         chk("pwm_oe", 10'h001, 10'(shared_pin_oe));
         k = t[0] ? 2 * (int'(v) + 1) - hi : hi;
         chk("pwm_active", w + w, 10'(k));
      end
      $display("test pwm done");
      for (int src = 0; src < 2; src++) begin
         k = $urandom_range(3, 0);
         load(10'h001, 10'h000);
         wr(dtpb_pkg::ADDR_CTRL_TWO, src[0] ? 8'h08 : 8'h00);
         wr(dtpb_pkg::ADDR_BUZZER_CTRL, {4'h8, src[0], 3'(k)});
         wr(dtpb_pkg::ADDR_CTRL_ONE, 8'h03);
         run(4 * (4 << k) + 1, hi, tg);
         chk("buzz_oe", 10'h001, 10'(shared_pin_oe));
         chk("buzz_toggles", 10'h004, 10'(tg));
      end
      wr(dtpb_pkg::ADDR_CTRL_ONE, 8'h83);
      run(64, hi, tg);
      chk("pwm_wins", 10'h000, 10'(hi));
      $display("test buzzer done");
      report_and_stop();
   end
endmodule
